// >>> include/port2_cfg_pkg.sv
// Constants and types shared by the port-2 configuration block
package port2_cfg_pkg;
  localparam logic [7:0] CFG2_ADDR        = 8'h12;
  localparam logic [7:0] CFG2_RESET       = 8'h00;
  localparam logic [7:0] CFG2_IMPL_MASK   = 8'hb4;
  localparam int         BIT_ALERT_MASK   = 7;
  localparam int         BIT_MANUAL_DSCHG = 5;
  localparam int         BIT_SOFT_EN      = 4;
  localparam int         BIT_DSCHG_EN     = 2;
  localparam logic [7:0] RD_IDLE_VALUE    = 8'h00;

  localparam int CLK_HZ                = 25_000_000;
  localparam int DISCHARGE_STEP_MS     = 100;
  localparam int DISCHARGE_STEP_CYCLES = CLK_HZ / 1000 * DISCHARGE_STEP_MS;
  localparam int STEP_CNT_W            = 24;
  localparam int PORT_COUNT            = 2;
  localparam int SYNC_W                = 4;

  typedef enum logic [0:0] {
    DIS_IDLE = 1'b0,
    DIS_RUN  = 1'b1
  } dis_state_e;
endpackage

// >>> core/discharge_timer.sv
// Discharge duration timer for one port
`timescale 1ns/1ns
`default_nettype none
module discharge_timer
  import port2_cfg_pkg::*;
#(
  parameter int STEP_CYCLES = DISCHARGE_STEP_CYCLES
) (
  input  wire logic       sys_clk,      // Device clock
  input  wire logic       rst_n,        // Async reset, active low
  input  wire logic       start,        // Begin a discharge
  input  wire logic [1:0] durationSel,  // Steps of 100 ms minus one
  output var  logic       active        // Discharge in progress
);
  localparam logic [STEP_CNT_W-1:0] STEP_LAST =
    STEP_CNT_W'(STEP_CYCLES - 1);

  dis_state_e            state;
  logic [STEP_CNT_W-1:0] stepCnt;
  logic [1:0]            stepsLeft;
  wire                   stepDone = (stepCnt == '0);

  // A start during a running discharge is ignored, the first one counts
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= DIS_IDLE;
      stepCnt   <= '0;
      stepsLeft <= 2'h0;
    end else begin
      case (state)
        DIS_IDLE: begin
          if (start) begin
            state     <= DIS_RUN;
            stepCnt   <= STEP_LAST;
            stepsLeft <= durationSel;
          end
        end
        DIS_RUN: begin
          if (stepDone) begin
            if (stepsLeft == 2'h0) begin
              state <= DIS_IDLE;
            end else begin
              stepsLeft <= stepsLeft - 2'h1;
              stepCnt   <= STEP_LAST;
            end
          end else begin
            stepCnt <= stepCnt - 1'b1;
          end
        end
        default: state <= DIS_IDLE;
      endcase
    end
  end

  assign active = (state == DIS_RUN);

  logic [STEP_CNT_W+1:0] runLen;
  logic [1:0]            runSel;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      runLen <= '0;
      runSel <= 2'h0;
    end else if (start && !active) begin
      runLen <= '0;
      runSel <= durationSel;
    end else if (active) begin
      runLen <= runLen + 1'b1;
    end
  end

  a_duration_exact: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(active) |-> int'(runLen) == (int'(runSel) + 1) * STEP_CYCLES)
    else $error("discharge length does not match the duration code");
endmodule // discharge_timer
`default_nettype wire

// >>> core/port2_config_discharge_ctrl.sv
// Port-2 configuration register with alert masking and discharge control
`timescale 1ns/1ns
`default_nettype none
module port2_config_discharge_ctrl
  import port2_cfg_pkg::*;
#(
  parameter int STEP_CYCLES = DISCHARGE_STEP_CYCLES
) (
  input  wire logic       sys_clk,                // Device clock, 25 MHz
  input  wire logic       rst_n,                  // Async reset, active low
  input  wire logic       regWrEn,                // Register write strobe
  input  wire logic       regRdEn,                // Register read strobe
  input  wire logic [7:0] regAddr,                // Register address
  input  wire logic [7:0] regWrData,              // Write data
  output var  logic [7:0] regRdData,              // Read data, next cycle
  input  wire logic       powerEnablePinP2,       // Port-2 enable pin
  input  wire logic       overvoltageFlagP2,      // Port-2 overvoltage
  input  wire logic       thermalShutdown,        // Thermal shutdown
  input  wire logic       otherEventP2,           // Any other port-2 event
  input  wire logic [1:0] autoDischargeTrig,      // Auto discharge, per port
  input  wire logic       manualDischargeWrP1,    // Port-1 request written 1
  input  wire logic [1:0] dischargeDurationSel,   // Shared duration code
  input  wire logic       loadDischargeReqP1,     // Port-1 load bit
  input  wire logic       loadDischargeReqP2,     // Port-2 load bit
  output var  logic       switchOnP2,             // Port-2 switch closed
  output var  logic [1:0] dischargeOn,            // Discharge circuit on
  output var  logic       loadDischargeWrAllowed, // Load bits writable
  output wire logic       alertOut2,              // Alert pin drive level
  output var  logic       alertOut2Oe             // Alert pin pulled low
);
  // Pin inputs: enable pin, overvoltage, thermal, other event
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {otherEventP2, thermalShutdown,
                overvoltageFlagP2, powerEnablePinP2};
      syncB <= syncA;
    end
  end

  wire pinEnS   = syncB[0];
  wire ovS      = syncB[1];
  wire tsdS     = syncB[2];
  wire otherS   = syncB[3];

  // Configuration register
  logic [7:0] cfgReg;
  wire alertMask       = cfgReg[BIT_ALERT_MASK];
  wire manualReqP2     = cfgReg[BIT_MANUAL_DSCHG];
  wire softPowerEnable = cfgReg[BIT_SOFT_EN];
  wire dischargeEnable = cfgReg[BIT_DSCHG_EN];

  wire cfgSel   = (regAddr == CFG2_ADDR);
  wire cfgWrite = regWrEn && cfgSel;
  wire cfgRead  = regRdEn && cfgSel;

  // Only the four implemented bits are stored
  wire [7:0] wrImpl = regWrData & CFG2_IMPL_MASK;
  // The request bit freezes while discharge is disabled
  wire       next_manualBit = dischargeEnable ?
    wrImpl[BIT_MANUAL_DSCHG] : manualReqP2;
  wire [7:0] next_cfg;
  assign next_cfg = {wrImpl[7:6], next_manualBit, wrImpl[4:0]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReg <= CFG2_RESET;
    end else if (cfgWrite) begin
      cfgReg <= next_cfg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= RD_IDLE_VALUE;
    end else if (cfgRead) begin
      regRdData <= cfgReg & CFG2_IMPL_MASK;
    end else begin
      regRdData <= RD_IDLE_VALUE;
    end
  end

  // Discharge starts
  wire manualStartP2 = cfgWrite && dischargeEnable &&
                       regWrData[BIT_MANUAL_DSCHG];
  wire manualStartP1 = manualDischargeWrP1 && dischargeEnable;
  wire [1:0] manualStart = {manualStartP2, manualStartP1};
  // Automatic discharges only start while enabled
  wire [1:0] autoStart = autoDischargeTrig &
                         {PORT_COUNT{dischargeEnable}};
  wire [1:0] timerStart = manualStart | autoStart;
  wire [1:0] timerActive;

  genvar p;
  generate
    for (p = 0; p < PORT_COUNT; p++) begin : g_port
      discharge_timer #(
        .STEP_CYCLES (STEP_CYCLES)
      ) u_timer (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .start       (timerStart[p]),
        .durationSel (dischargeDurationSel),
        .active      (timerActive[p])
      );
    end
  endgenerate

  // Load-discharge bits act only while the auto discharge is disabled
  wire       next_loadAllowed = ~dischargeEnable;
  wire [1:0] loadReq = {loadDischargeReqP2, loadDischargeReqP1};
  wire [1:0] next_dischargeOn = timerActive |
    (loadReq & {PORT_COUNT{next_loadAllowed}});
  // A port-2 discharge overrides the enables so the bus is not fed while drained
  wire next_switchOn = (softPowerEnable | pinEnS) &
                       ~next_dischargeOn[1];
  wire next_alert = ovS | tsdS | (~alertMask & otherS);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dischargeOn            <= 2'h0;
      switchOnP2             <= 1'b0;
      alertOut2Oe            <= 1'b0;
      loadDischargeWrAllowed <= 1'b0;
    end else begin
      dischargeOn            <= next_dischargeOn;
      switchOnP2             <= next_switchOn;
      alertOut2Oe            <= next_alert;
      loadDischargeWrAllowed <= next_loadAllowed;
    end
  end

  // Open-drain alert only ever pulls low
  assign alertOut2 = 1'b0;

  sequence seqManualWrite;
    cfgWrite && dischargeEnable && regWrData[BIT_MANUAL_DSCHG] &&
    !timerActive[1];
  endsequence

  sequence seqDrainP2;
    timerActive[1] ##1 (dischargeOn[1] && !switchOnP2);
  endsequence

  a_alert_masked: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (alertMask && !ovS && !tsdS) |=> !alertOut2Oe)
    else $error("masked port-2 event reached the alert pin");

  a_alert_fault: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ovS || tsdS) |=> alertOut2Oe)
    else $error("overvoltage or thermal event did not raise the alert");

  a_manual_start: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    seqManualWrite |=> seqDrainP2)
    else $error("manual port-2 discharge did not open the switch");

  a_pin_or: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ((softPowerEnable || pinEnS) && !next_dischargeOn[1]) |=> switchOnP2)
    else $error("port-2 switch not on with an enable present");

  a_auto_suppress: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!dischargeEnable && !timerActive[0]) |=> !timerActive[0])
    else $error("automatic discharge ran while disabled");

  a_manual_ignored: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (cfgWrite && !dischargeEnable) |=> $stable(manualReqP2))
    else $error("manual request bit changed while disabled");

  a_auto_runs: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (dischargeEnable && autoDischargeTrig[0] && !timerActive[0]) |=>
    timerActive[0])
    else $error("automatic discharge did not start while enabled");

  a_load_ignored: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (dischargeEnable && !timerActive[1]) |=> !dischargeOn[1])
    else $error("load-discharge bit acted while auto discharge enabled");

  a_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    regRdEn |=> (regRdData[6] == 1'b0 && regRdData[3] == 1'b0))
    else $error("unimplemented bit read as one");

  a_drain_blocks: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    dischargeOn[1] |-> !switchOnP2)
    else $error("port-2 switch closed during a discharge");

  a_load_acts: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!dischargeEnable && loadDischargeReqP2) |=> dischargeOn[1])
    else $error("port-2 load bit did not discharge while disabled");

  a_p1_ignored: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (manualDischargeWrP1 && !dischargeEnable && !timerActive[0]) |=>
    !timerActive[0])
    else $error("port-1 manual request started while disabled");

  a_load_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    dischargeEnable |=> !loadDischargeWrAllowed)
    else $error("load bits writable while auto discharge enabled");
endmodule // port2_config_discharge_ctrl
`default_nettype wire

// >>> testbench/cfg_host.sv
// Host model that drives the register strobes and the load-discharge bits
`timescale 1ns/1ns
`default_nettype none
module cfg_host (
  input  wire logic       sys_clk, // Device clock
  input  wire logic [7:0] rdData,  // Read data from the block
  output var  logic       wrEn,    // Write strobe
  output var  logic       rdEn,    // Read strobe
  output var  logic [7:0] addr,    // Register address
  output var  logic [7:0] wrData,  // Write data
  output var  logic [1:0] loadReq  // Load-discharge bits, [1] is port 2
);
  initial begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 8'h00;
    wrData = 8'h00;
    loadReq = 2'b00;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge sys_clk);
    wrEn <= 1'b0;
    addr <= ~a;
    wrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rdEn <= 1'b0;
    addr <= ~a;
    #1 d = rdData;
  endtask
  // Host sets and later clears a load bit itself
  task automatic loadSet(input int p, input logic v);
    @(posedge sys_clk);
    loadReq[p] <= v;
  endtask
endmodule // cfg_host
`default_nettype wire

// >>> testbench/port2_config_discharge_ctrl_bench.sv
// Self-checking bench for the port-2 configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin \
  nChecks++; \
  if ((a) !== (b)) begin \
    errTotal++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); \
  end \
end
module port2_config_discharge_ctrl_bench;
  import port2_cfg_pkg::*;
  localparam int STEP = 4;
  localparam logic [4:0] ATAB [5] = '{5'h12, 5'h19, 5'h15, 5'h03, 5'h10};
  logic       sys_clk, rst_n, wrEn, rdEn, pin, ov, thermal_shutdown, other, manP1;
  logic       switchOn, loadOk, alert, alertOe, so;
  logic [7:0] addr, wrData, rdData, d;
  logic [1:0] autoTrig, durSel, loadReq, dis;
  logic [4:0] v;
  int         errTotal, nChecks, cyc, w;

  port2_config_discharge_ctrl #(.STEP_CYCLES(STEP))
    i_port2_config_discharge_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .regWrEn(wrEn), .regRdEn(rdEn),
    .regAddr(addr), .regWrData(wrData), .regRdData(rdData),
    .powerEnablePinP2(pin), .overvoltageFlagP2(ov), .thermalShutdown(thermal_shutdown),
    .otherEventP2(other), .autoDischargeTrig(autoTrig),
    .manualDischargeWrP1(manP1), .dischargeDurationSel(durSel),
    .loadDischargeReqP1(loadReq[0]), .loadDischargeReqP2(loadReq[1]),
    .switchOnP2(switchOn), .dischargeOn(dis),
    .loadDischargeWrAllowed(loadOk), .alertOut2(alert),
    .alertOut2Oe(alertOe));
  cfg_host i_cfg_host (.sys_clk(sys_clk), .rdData(rdData), .wrEn(wrEn),
    .rdEn(rdEn), .addr(addr), .wrData(wrData), .loadReq(loadReq));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Bounded wait for a discharge, then count its cycles
  task automatic width(input int p);
    w = 0;
    for (int k = 0; k < 20 && dis[p] !== 1'b1; k++) tick(1);
    so = switchOn;
    while (dis[p] === 1'b1 && w < 40) begin
      tick(1);
      w++;
    end
  endtask
  task automatic pulse(input logic [1:0] t, input logic m);
    @(posedge sys_clk);
    autoTrig <= t;
    manP1 <= m;
    @(posedge sys_clk);
    autoTrig <= 2'b00;
    manP1 <= 1'b0;
  endtask
  task automatic results();
    if (errTotal == 0 && nChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errTotal++;
      results();
    end
  end

  initial begin
    {rst_n, pin, ov, thermal_shutdown, other, manP1} = 6'h00;
    {autoTrig, durSel} = 4'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    i_cfg_host.rd(CFG2_ADDR, d);
    `CHK(d, CFG2_RESET)
    i_cfg_host.wr(CFG2_ADDR, 8'hff);
    i_cfg_host.wr(8'h13, 8'h00);
    i_cfg_host.rd(8'h13, d);
    `CHK(d, 8'h00)
    i_cfg_host.rd(CFG2_ADDR, d);
    `CHK(d, 8'h94)
    `CHK(dis, 2'b00)
    `CHK(switchOn, 1'b1)
    i_cfg_host.wr(CFG2_ADDR, 8'h04);
    tick(4);
    `CHK(switchOn, 1'b0)
    @(posedge sys_clk) pin <= 1'b1;
    tick(5);
    `CHK(switchOn, 1'b1)
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk) durSel <= 2'(s);
      i_cfg_host.wr(CFG2_ADDR, 8'h24);
      width(1);
      `CHK(w, (s + 1) * STEP)
      `CHK(so, 1'b0)
      i_cfg_host.wr(CFG2_ADDR, 8'h04);
    end
    @(posedge sys_clk) durSel <= 2'b00;
    pulse(2'b01, 1'b0);
    width(0);
    `CHK(w, STEP)
    pulse(2'b00, 1'b1);
    width(0);
    `CHK(w, STEP)
    // Disable first, so the later request write meets a cleared enable
    i_cfg_host.wr(CFG2_ADDR, 8'h00);
    i_cfg_host.wr(CFG2_ADDR, 8'h20);
    pulse(2'b11, 1'b1);
    tick(3);
    `CHK(dis, 2'b00)
    i_cfg_host.rd(CFG2_ADDR, d);
    `CHK(d, 8'h00)
    `CHK(loadOk, 1'b1)
    i_cfg_host.loadSet(1, 1'b1);
    tick(2);
    `CHK(dis, 2'b10)
    i_cfg_host.loadSet(1, 1'b0);
    tick(2);
    `CHK(dis, 2'b00)
    i_cfg_host.wr(CFG2_ADDR, 8'h04);
    tick(1);
    `CHK(loadOk, 1'b0)
    i_cfg_host.loadSet(0, 1'b1);
    tick(3);
    `CHK(dis, 2'b00)
    i_cfg_host.loadSet(0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      v = ATAB[i];
      i_cfg_host.wr(CFG2_ADDR, {v[4], 7'h00});
      @(posedge sys_clk) {ov, thermal_shutdown, other} <= v[3:1];
      tick(5);
      `CHK(alertOe, v[0])
      `CHK(alert, 1'b0)
    end
    results();
  end
endmodule // port2_config_discharge_ctrl_bench
`default_nettype wire
